/* design/vam_core.sv */
/*
 Voltage angle memory: substitutes a frozen-angle reference voltage when
 all used voltages collapse, for a limited time, and reports events.
 Assumes measurements and settings come from logic on MCLK_IN; the
 blocking input is a pin and is synchronised here.
*/
// Behaviour
// - Voltage-low holds only when every voltage in use is under threshold.
// - With the current condition on, one phase current must also exceed pick-up.
// - The activation threshold is clamped to 2..50 V and compared to voltages.
// - Nothing activates while the memory enable setting is off.
// - While active, the reference amplitude is the activation threshold.
// - Angles are tracked continuously and frozen at activation.
// - A memory-active status output stands while memory is in use.
// - A definite-time timer of 0.02..50.00 s limits memory use.
// - On timer expiry, dependent stages are told to go non-directional.
// - Blocking is sampled once per program cycle and suppresses memory.
// - Forced current tracking picks the phase-three current when voltage is gone.
// - ON/OFF events are emitted for each condition plus enable/disable.
`timescale 1ns/100ps
`default_nettype none
module vam_core #(
  parameter int CYCLE_DIV = vam_pkg::CYCLE_DIV_DEFAULT,
  parameter int TICK_DIV  = vam_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                      MCLK_IN,
  input  wire logic                      NRST_IN,
  // Settings
  input  wire logic                      MEM_ENABLE_IN,
  input  wire logic [vam_pkg::VOLT_W-1:0] ACT_VOLT_IN,
  input  wire logic                      CURR_COND_EN_IN,
  input  wire logic [vam_pkg::CURR_W-1:0] CURR_PICKUP_IN,
  input  wire logic [12:0]               MAX_TIME_IN,
  input  wire logic                      FORCE_CT_TRACK_IN,
  input  wire logic [2:0]                VOLT_USED_IN,
  // Measurements
  input  wire logic [3*vam_pkg::VOLT_W-1:0] VOLT_MAG_IN,
  input  wire logic [3*vam_pkg::ANG_W-1:0]  VOLT_ANG_IN,
  input  wire logic [3*vam_pkg::CURR_W-1:0] CURR_MAG_IN,
  // Blocking pin
  input  wire logic                      BLOCK_IN,
  // Reference to stages
  output logic [vam_pkg::VOLT_W-1:0]     REF_AMP_OUT,
  output logic [3*vam_pkg::ANG_W-1:0]    REF_ANG_OUT,
  output logic                           MEM_ACTIVE_OUT,
  output logic                           NONDIR_OUT,
  output logic [2:0]                     FREQ_REF_OUT,
  // Events
  output logic                           EVENT_VALID_OUT,
  output logic [3:0]                     EVENT_CODE_OUT
);
  typedef struct packed {
    logic                        blk_s1;
    logic                        blk_s2;
    logic                        blk;
    vam_pkg::vam_state_t         state;
    logic [12:0]                 timer;
    logic [3*vam_pkg::ANG_W-1:0] ang;
    logic [vam_pkg::VOLT_W-1:0]  amp;
    logic                        vlow;
    logic                        ihigh;
    logic                        ftrk;
    logic                        en;
    logic [5:0]                  pend;
    logic                        ev_v;
    logic [3:0]                  ev_c;
  } vam_st_t;

  vam_st_t st_r;
  vam_st_t st_nxt;
  logic    cyc_tick;
  logic    time_tick;

  vam_divider #(.DIV(CYCLE_DIV)) u_cycle (
    .clk_in   (MCLK_IN),
    .nrst_in  (NRST_IN),
    .tick_out (cyc_tick)
  );

  vam_divider #(.DIV(TICK_DIV)) u_time (
    .clk_in   (MCLK_IN),
    .nrst_in  (NRST_IN),
    .tick_out (time_tick)
  );

  logic [vam_pkg::VOLT_W-1:0] thr;
  logic [12:0]                tmax;
  logic                       vlow_c;
  logic                       ihigh_c;
  logic                       cond;

  always_comb
  begin
    // Out-of-range settings are clamped rather than rejected
    thr = ACT_VOLT_IN;
    if (thr < vam_pkg::ACT_VOLT_MIN)
      thr = vam_pkg::ACT_VOLT_MIN;
    else if (thr > vam_pkg::ACT_VOLT_MAX)
      thr = vam_pkg::ACT_VOLT_MAX;
    tmax = MAX_TIME_IN;
    if (tmax < vam_pkg::MAX_TIME_MIN)
      tmax = vam_pkg::MAX_TIME_MIN;
    else if (tmax > vam_pkg::MAX_TIME_MAX)
      tmax = vam_pkg::MAX_TIME_MAX;
    // No used channel means no evidence of collapse
    vlow_c  = (VOLT_USED_IN != 3'h0);
    ihigh_c = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (VOLT_USED_IN[i] &&
          VOLT_MAG_IN[i*vam_pkg::VOLT_W +: vam_pkg::VOLT_W] >= thr)
        vlow_c = 1'b0;
      if (CURR_MAG_IN[i*vam_pkg::CURR_W +: vam_pkg::CURR_W] > CURR_PICKUP_IN)
        ihigh_c = 1'b1;
    end
    cond  = vlow_c && (!CURR_COND_EN_IN || ihigh_c);
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ev_v = 1'b0;
    st_nxt.ev_c = vam_pkg::EV_NONE;
    st_nxt.blk_s1 = BLOCK_IN;
    st_nxt.blk_s2 = st_r.blk_s1;
    if (cyc_tick)
      st_nxt.blk = st_r.blk_s2;
    st_nxt.en    = MEM_ENABLE_IN;
    st_nxt.vlow  = vlow_c;
    st_nxt.ihigh = ihigh_c;
    st_nxt.ftrk  = FORCE_CT_TRACK_IN && vlow_c;

    case (st_r.state)
      vam_pkg::ST_IDLE:
      begin
        st_nxt.ang = VOLT_ANG_IN;
        if (st_r.en && !st_r.blk && cond)
        begin
          st_nxt.state = vam_pkg::ST_ACTIVE;
          st_nxt.amp   = thr;
          st_nxt.timer = tmax;
        end
      end
      vam_pkg::ST_ACTIVE:
      begin
        if (st_r.blk || !st_r.en || !vlow_c)
          st_nxt.state = vam_pkg::ST_IDLE;
        else if (time_tick)
        begin
          if (st_r.timer <= 13'h0001)
          begin
            st_nxt.timer = 13'h0000;
            st_nxt.state = vam_pkg::ST_EXPIRED;
          end
          else
            st_nxt.timer = st_r.timer - 13'h0001;
        end
      end
      vam_pkg::ST_EXPIRED:
      begin
        // Stays non-directional until voltage recovers or memory is blocked or disabled
        st_nxt.ang = VOLT_ANG_IN;
        if (st_r.blk || !st_r.en || !vlow_c)
          st_nxt.state = vam_pkg::ST_IDLE;
      end
      default:
        st_nxt.state = vam_pkg::ST_IDLE;
    endcase
    // Amplitude register is cleared outside memory use
    if (st_nxt.state != vam_pkg::ST_ACTIVE)
      st_nxt.amp = '0;

    // Changes queue in pend and drain one event per clock
    if (st_nxt.en != st_r.en)
      st_nxt.pend[0] = 1'b1;
    if (st_nxt.vlow != st_r.vlow)
      st_nxt.pend[1] = 1'b1;
    if (st_nxt.ihigh != st_r.ihigh)
      st_nxt.pend[2] = 1'b1;
    if (st_nxt.ftrk != st_r.ftrk)
      st_nxt.pend[3] = 1'b1;
    if ((st_nxt.state == vam_pkg::ST_ACTIVE) !=
        (st_r.state == vam_pkg::ST_ACTIVE))
      st_nxt.pend[4] = 1'b1;
    if (st_nxt.blk != st_r.blk)
      st_nxt.pend[5] = 1'b1;
    if (st_r.pend[0])
    begin
      st_nxt.ev_v = 1'b1;
      st_nxt.ev_c = st_r.en ? vam_pkg::EV_ENABLED : vam_pkg::EV_DISABLED;
      st_nxt.pend[0] = st_nxt.en != st_r.en;
    end
    else if (st_r.pend[1])
    begin
      st_nxt.ev_v = 1'b1;
      st_nxt.ev_c = st_r.vlow ? vam_pkg::EV_VLOW_ON : vam_pkg::EV_VLOW_OFF;
      st_nxt.pend[1] = st_nxt.vlow != st_r.vlow;
    end
    else if (st_r.pend[2])
    begin
      st_nxt.ev_v = 1'b1;
      st_nxt.ev_c = st_r.ihigh ? vam_pkg::EV_IHIGH_ON : vam_pkg::EV_IHIGH_OFF;
      st_nxt.pend[2] = st_nxt.ihigh != st_r.ihigh;
    end
    else if (st_r.pend[3])
    begin
      st_nxt.ev_v = 1'b1;
      st_nxt.ev_c = st_r.ftrk ? vam_pkg::EV_FTRK_ON : vam_pkg::EV_FTRK_OFF;
      st_nxt.pend[3] = st_nxt.ftrk != st_r.ftrk;
    end
    else if (st_r.pend[4])
    begin
      st_nxt.ev_v = 1'b1;
      st_nxt.ev_c = (st_r.state == vam_pkg::ST_ACTIVE) ?
                    vam_pkg::EV_USE_ON : vam_pkg::EV_USE_OFF;
      // A new change in the same cycle must not be lost
      st_nxt.pend[4] = (st_nxt.state == vam_pkg::ST_ACTIVE) !=
                       (st_r.state == vam_pkg::ST_ACTIVE);
    end
    else if (st_r.pend[5])
    begin
      st_nxt.ev_v = 1'b1;
      st_nxt.ev_c = st_r.blk ? vam_pkg::EV_BLOCK_ON : vam_pkg::EV_BLOCK_OFF;
      st_nxt.pend[5] = st_nxt.blk != st_r.blk;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Outside memory use the stages see live angles and a zero amplitude
  assign MEM_ACTIVE_OUT  = (st_r.state == vam_pkg::ST_ACTIVE);
  assign REF_AMP_OUT     = st_r.amp;
  assign REF_ANG_OUT     = st_r.ang;
  assign NONDIR_OUT      = (st_r.state == vam_pkg::ST_EXPIRED);
  assign FREQ_REF_OUT    = st_r.ftrk ? vam_pkg::FREQ_REF_PHASE3 :
                           vam_pkg::FREQ_REF_NONE;
  assign EVENT_VALID_OUT = st_r.ev_v;
  assign EVENT_CODE_OUT  = st_r.ev_c;
endmodule
`default_nettype wire

/* design/vam_pkg.sv */
/*
 Shared constants for the voltage angle memory block: widths, setting
 limits, program-cycle timing and event codes.
 Assumes measured quantities arrive as unsigned fixed-point words.
*/
package vam_pkg;
  // Voltages in units of 10 mV, currents in units of 1 mA
  localparam int          VOLT_W = 16;
  localparam int          CURR_W = 20;
  localparam int          ANG_W  = 16;
  localparam logic [15:0] ACT_VOLT_MIN = 16'h00c8; // 2 V
  localparam logic [15:0] ACT_VOLT_MAX = 16'h1388; // 50 V
  // Max active time in units of 10 ms
  localparam logic [12:0] MAX_TIME_MIN = 13'h0002; // 0.02 s
  localparam logic [12:0] MAX_TIME_MAX = 13'h1388; // 50.00 s
  localparam int          TICK_NS = 10000000;      // 10 ms time base
  localparam int          CLK_NS  = 8;
  localparam int          TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int          CYCLE_DIV_DEFAULT = 125000; // 1 ms program cycle
  localparam logic [2:0]  FREQ_REF_PHASE3 = 3'h3;
  localparam logic [2:0]  FREQ_REF_NONE   = 3'h0;
  // Event codes
  typedef enum logic [3:0] {
    EV_NONE       = 4'h0,
    EV_ENABLED    = 4'h1,
    EV_DISABLED   = 4'h2,
    EV_VLOW_ON    = 4'h3,
    EV_VLOW_OFF   = 4'h4,
    EV_IHIGH_ON   = 4'h5,
    EV_IHIGH_OFF  = 4'h6,
    EV_FTRK_ON    = 4'h7,
    EV_FTRK_OFF   = 4'h8,
    EV_USE_ON     = 4'h9,
    EV_USE_OFF    = 4'ha,
    EV_BLOCK_ON   = 4'hb,
    EV_BLOCK_OFF  = 4'hc
  } vam_event_t;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ACTIVE  = 2'b01,
    ST_EXPIRED = 2'b10
  } vam_state_t;
endpackage

/* design/vam_divider.sv */
/*
 Free-running divider producing a one-cycle enable pulse every DIV clocks.
 Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module vam_divider #(
  parameter int DIV = 1250000
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  output logic      tick_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } vam_div_st_t;

  vam_div_st_t st_r;
  vam_div_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= 32'(DIV - 1))
    begin
      st_nxt.cnt  = 32'h0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick_out = st_r.tick;
endmodule
`default_nettype wire

/* verification/vam_stage_model.sv */
/*
 Model of the directional and distance stages fed by the memory block.
 Assumes the block's outputs are registered on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module vam_stage_model (
  // Clock
  input  wire logic       clk_in,
  // Reference status
  input  wire logic       mem_active_in,
  input  wire logic       nondir_in,
  // Stage mode: 0 measured angle, 1 memory angle, 2 non-directional
  output logic [1:0]      mode_out
);
  // Expiry overrides memory so that tripping stays possible
  always_ff @(posedge clk_in)
    mode_out <= nondir_in ? 2'h2 : {1'b0, mem_active_in};
endmodule
`default_nettype wire

/* verification/vam_assertions.sv */
/*
 Concurrent checks on the voltage angle memory ports.
 Assumes it is bound to vam_core and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module vam_assertions (
  // Clock and reset
  input wire logic        MCLK_IN,
  input wire logic        NRST_IN,
  // Settings
  input wire logic        MEM_ENABLE_IN,
  input wire logic        FORCE_CT_TRACK_IN,
  // Outputs
  input wire logic [15:0] REF_AMP_OUT,
  input wire logic [47:0] REF_ANG_OUT,
  input wire logic        MEM_ACTIVE_OUT,
  input wire logic        NONDIR_OUT,
  input wire logic [2:0]  FREQ_REF_OUT,
  input wire logic        EVENT_VALID_OUT,
  input wire logic [3:0]  EVENT_CODE_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence held_s;
    MEM_ACTIVE_OUT ##1 MEM_ACTIVE_OUT;
  endsequence
  sequence use_on_s;
    EVENT_VALID_OUT && EVENT_CODE_OUT == vam_pkg::EV_USE_ON;
  endsequence
  chk_amp_range: assert property (held_s |->
    REF_AMP_OUT >= vam_pkg::ACT_VOLT_MIN && REF_AMP_OUT <= vam_pkg::ACT_VOLT_MAX)
    else $error("reference amplitude outside threshold range");
  chk_angle_frozen: assert property (held_s |-> $stable(REF_ANG_OUT))
    else $error("reference angle moved while active");
  chk_nondir_excl: assert property (NONDIR_OUT |-> !MEM_ACTIVE_OUT)
    else $error("non-directional while memory active");
  chk_nondir_cause: assert property ($rose(NONDIR_OUT) |-> $past(MEM_ACTIVE_OUT))
    else $error("non-directional without expiry");
  chk_disabled_idle: assert property (!MEM_ENABLE_IN [*4] |-> !MEM_ACTIVE_OUT)
    else $error("memory active while disabled");
  chk_use_event: assert property ($rose(MEM_ACTIVE_OUT) |-> ##[1:8] use_on_s)
    else $error("no use event after activation");
  chk_event_code: assert property (EVENT_VALID_OUT |->
    EVENT_CODE_OUT inside {[4'h1:4'hc]})
    else $error("event pulse with bad code");
  chk_track_off: assert property (!FORCE_CT_TRACK_IN [*3] |-> FREQ_REF_OUT == 3'h0)
    else $error("current tracking without forcing");
  chk_track_phase: assert property (FREQ_REF_OUT != 3'h0 |-> FREQ_REF_OUT == 3'h3)
    else $error("tracking reference not phase three");
endmodule
bind vam_core vam_assertions i_chk (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
  .MEM_ENABLE_IN(MEM_ENABLE_IN), .FORCE_CT_TRACK_IN(FORCE_CT_TRACK_IN),
  .REF_AMP_OUT(REF_AMP_OUT), .REF_ANG_OUT(REF_ANG_OUT),
  .MEM_ACTIVE_OUT(MEM_ACTIVE_OUT), .NONDIR_OUT(NONDIR_OUT),
  .FREQ_REF_OUT(FREQ_REF_OUT), .EVENT_VALID_OUT(EVENT_VALID_OUT),
  .EVENT_CODE_OUT(EVENT_CODE_OUT));
`default_nettype wire

/* verification/testbench.sv */
/*
 Self-checking bench for vam_core with short program cycle and tick.
 Assumes the stage model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk, nrst, en, cc, frc, blk, mem_act, nondir, ev_v;
  logic [15:0] act, amp, seen;
  logic [19:0] pick;
  logic [12:0] maxt;
  logic [2:0]  used, fref;
  logic [47:0] vmag, ang, rang;
  logic [59:0] cmag;
  logic [3:0]  ev_c;
  logic [1:0]  mode;
  int          failures, comparisons;
  localparam logic [15:0] HI = 16'h2710;
  localparam logic [15:0] LO = 16'h0064;
  vam_core #(.CYCLE_DIV(4), .TICK_DIV(10)) i_dut (.MCLK_IN(clk), .NRST_IN(nrst),
    .MEM_ENABLE_IN(en), .ACT_VOLT_IN(act), .CURR_COND_EN_IN(cc),
    .CURR_PICKUP_IN(pick), .MAX_TIME_IN(maxt), .FORCE_CT_TRACK_IN(frc),
    .VOLT_USED_IN(used), .VOLT_MAG_IN(vmag), .VOLT_ANG_IN(ang),
    .CURR_MAG_IN(cmag), .BLOCK_IN(blk), .REF_AMP_OUT(amp), .REF_ANG_OUT(rang),
    .MEM_ACTIVE_OUT(mem_act), .NONDIR_OUT(nondir), .FREQ_REF_OUT(fref),
    .EVENT_VALID_OUT(ev_v), .EVENT_CODE_OUT(ev_c));
  vam_stage_model i_stage (.clk_in(clk), .mem_active_in(mem_act),
    .nondir_in(nondir), .mode_out(mode));
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({63'h0, got}, {63'h0, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait: block and tick alignment make the latency vary
  task automatic wait_act(input logic e, input int n);
    int i;
    i = 0;
    #1;
    while (mem_act !== e && i < n)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk_bit(mem_act, e);
  endtask
  task automatic conclude;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (!nrst)
      seen <= '0;
    else if (ev_v === 1'b1)
      seen[ev_c] <= 1'b1;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #200000;
    failures++;
    conclude();
  end
  initial
  begin
    {nrst, cc, blk, cmag, failures, comparisons} = '0;
    {en, frc, used, maxt, pick, act} = {2'b11, 3'h7, 13'h0002, 20'h00100, 16'h03e8};
    vmag = {HI, HI, HI};
    ang = 48'h1111_2222_3333;
    step(6);
    nrst <= 1'b1;
    step(10);
    vmag <= {HI, LO, LO};
    step(8);
    wait_act(1'b0, 0);
    step(1);
    vmag <= {LO, LO, LO};
    wait_act(1'b1, 10);
    chk_word(amp, 16'h03e8);
    chk_word(rang, 48'h1111_2222_3333);
    chk_word(fref, 3'h3);
    step(1);
    ang <= 48'h4444_5555_6666;
    step(3);
    #1 chk_word(rang, 48'h1111_2222_3333);
    wait_act(1'b0, 60);
    step(2);
    #1 chk_bit(nondir, 1'b1);
    chk_word(mode, 2'h2);
    chk_word(rang, 48'h4444_5555_6666);
    chk_word(amp, 16'h0000);
    step(1);
    vmag <= {HI, HI, HI};
    step(4);
    #1 chk_bit(nondir, 1'b0);
    step(1);
    {act, maxt, vmag} <= {16'h0010, 13'h0005, LO, LO, LO};
    wait_act(1'b1, 10);
    chk_word(amp, 16'h00c8);
    step(1);
    blk <= 1'b1;
    wait_act(1'b0, 14);
    step(8);
    wait_act(1'b0, 0);
    step(1);
    blk <= 1'b0;
    wait_act(1'b1, 14);
    step(1);
    {act, vmag, cc} <= {16'h03e8, HI, HI, HI, 1'b1};
    wait_act(1'b0, 10);
    step(1);
    vmag <= {LO, LO, LO};
    step(10);
    wait_act(1'b0, 0);
    step(1);
    cmag <= {20'h0, 20'h00200, 20'h0};
    wait_act(1'b1, 10);
    step(1);
    {cmag, vmag, cc, en, frc} <= {60'h0, HI, HI, HI, 3'b000};
    wait_act(1'b0, 10);
    step(1);
    vmag <= {LO, LO, LO};
    step(10);
    wait_act(1'b0, 0);
    chk_word(fref, 3'h0);
    step(1);
    {en, vmag} <= {1'b1, HI, HI, HI};
    step(12);
    chk_word(seen, 16'h1ffe);
    conclude();
  end
endmodule
`default_nettype wire
